// ---- rtl/adc_seq_pkg.sv ----
package adc_seq_pkg;
	// Clock and documented timing figures.
	localparam int CLK_PERIOD_NS  = 4;
	localparam int CONV_TIME_NS   = 20000;
	localparam int ACQ_TIME_NS    = 4000;
	localparam int PD_RESET_NS    = 200;
	localparam int SETTLE_TIME_NS = 1000000;
	localparam int RC_LOW_NS      = 40;
	// Least times round up to whole cycles.
	localparam int CONV_CYC_DEF   = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int ACQ_CYC        = (ACQ_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int PD_RESET_CYC   = (PD_RESET_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SETTLE_CYC_DEF = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RC_LOW_CYC     = (RC_LOW_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// Host register map, byte addresses.
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] CMD_OFS    = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	// Control register fields.
	localparam int CTRL_CONT_BIT = 0;
	localparam int CTRL_PD_BIT   = 1;
	localparam int CTRL_ADDR_LSB = 2;
	localparam int CTRL_CS_BIT   = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	// Command register fields, write only.
	localparam int CMD_START_BIT = 0;
	localparam int CMD_CLEAR_BIT = 1;
	// Status register fields.
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_CONT_BIT = 2;
	localparam int STAT_PD_BIT   = 3;
	localparam int STAT_PEND_BIT = 4;
	localparam int STAT_ADDR_LSB = 8;
	// Bus answers.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Cycles the host waits before driving the address pins again.
	localparam int OE_GAP = 4;
	typedef enum logic {ST_ACQ, ST_CONV} conv_state_t;
endpackage

// ---- rtl/adc_link_if.sv ----
`timescale 1ns/1ps
interface adc_link_if;
	logic       cs_n;
	logic       rd_conv;
	logic       power_down;
	logic       continuous_mode_sel;
	logic       busy_n;
	logic [1:0] addr_host_o;
	logic       addr_host_oe;
	logic [1:0] addr_dev_o;
	logic       addr_dev_oe;
	logic       chan_addr_bit0;
	logic       chan_addr_bit1;

	// Wire level of the two-way address pins; a weak pull-down when idle.
	assign chan_addr_bit0 = addr_dev_oe ? addr_dev_o[0] :
		(addr_host_oe ? addr_host_o[0] : 1'b0);
	assign chan_addr_bit1 = addr_dev_oe ? addr_dev_o[1] :
		(addr_host_oe ? addr_host_o[1] : 1'b0);

	modport device (
		input  cs_n, rd_conv, power_down, continuous_mode_sel,
		input  chan_addr_bit0, chan_addr_bit1,
		output busy_n, addr_dev_o, addr_dev_oe
	);
	modport host (
		output cs_n, rd_conv, power_down, continuous_mode_sel,
		output addr_host_o, addr_host_oe,
		input  busy_n, chan_addr_bit0, chan_addr_bit1
	);
endinterface

// ---- rtl/sync2.sv ----
`timescale 1ns/1ps
module sync2 #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// Two stages; only the second stage reads the first.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= INIT;
			q        <= INIT;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// ---- rtl/adc_seq_device.sv ----
// Function
// RULE_01 - Continuous mode converts back to back while enabled
// RULE_02 - Manual start captures address for next conversion
// RULE_03 - Convert commands ignored while busy low
// RULE_04 - Start by edge on read/convert or select
// RULE_05 - Power-down flags any overlapping result meaningless
// RULE_06 - Busy rise advances and drives next channel
// RULE_07 - Continuous edge restarts sequence on next channel
// RULE_08 - Continuous power-down resets next channel to zero
// RULE_09 - Last loaded address seeds the continuous sequence
// RULE_10 - Continuous mode turns address pins into outputs
// RULE_11 - Address shows current channel, data previous one
// RULE_12 - Long idle power-down pulse clears the address
// RULE_13 - Sequence counts upward, wrapping after channel three
// RULE_14 - Host waits for capacitor settling before continuous
// RULE_15 - Host waits acquisition time after short power-down
// RULE_16 - Captured address selects input in plain binary
// RULE_17 - Acquisition of new input starts at busy rise
// RULE_18 - Busy low from start until result stored
`timescale 1ns/1ps
module adc_seq_device #(
	parameter int CONV_CYC = adc_seq_pkg::CONV_CYC_DEF
) (
	input  wire logic clk,
	input  wire logic arst_n,
	adc_link_if.device link,
	output logic [1:0] conv_chan,
	output logic [1:0] data_chan,
	output logic       result_strobe,
	output logic       result_bad,
	output logic       analog_on
);
	import adc_seq_pkg::*;

	// A timer wider than 16 bits is not supported.
	if (CONV_CYC < 2 || CONV_CYC > 65535) begin : g_chk
		$error("CONV_CYC out of range");
	end

	// Next channel of the four, wrapping after the last.
	function automatic logic [1:0] next_chan(input logic [1:0] c);
		next_chan = c + 2'h1;
	endfunction

	logic [5:0]  pin_s;
	logic        cs_s;
	logic        rc_s;
	logic        pd_s;
	logic        cont_s;
	logic [1:0]  addr_s;
	logic        cs_prev_reg;
	logic        rc_prev_reg;
	logic        pd_prev_reg;
	logic        cont_prev_reg;
	conv_state_t st_reg;
	logic [15:0] tmr_reg;
	logic        busy_n_reg;
	logic [1:0]  sel_chan_reg;
	logic [1:0]  latch_reg;
	logic        oe_reg;
	logic [7:0]  pd_cnt_reg;
	logic        bad_acc_reg;
	logic        edge_cmd;
	logic        start_cmd;
	logic        restart;
	logic        auto_start;
	logic        conv_end;
	logic        pd_long;
	logic        pd_fall;

	// Every control pin comes from the other party and is synchronised.
	sync2 #(
		.W    (6),
		.INIT (6'h30)
	) u_pin_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({link.cs_n, link.rd_conv, link.power_down,
			link.continuous_mode_sel, link.chan_addr_bit1,
			link.chan_addr_bit0}),
		.q      (pin_s)
	);

	assign cs_s   = pin_s[5];
	assign rc_s   = pin_s[4];
	assign pd_s   = pin_s[3];
	assign cont_s = pin_s[2];
	assign addr_s = pin_s[1:0];

	// Previous levels for edge detection, taken from synchronised copies.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_prev_reg   <= 1'b1;
			rc_prev_reg   <= 1'b1;
			pd_prev_reg   <= 1'b0;
			cont_prev_reg <= 1'b0;
		end else begin
			cs_prev_reg   <= cs_s;
			rc_prev_reg   <= rc_s;
			pd_prev_reg   <= pd_s;
			cont_prev_reg <= cont_s;
		end
	end

	// A command edge counts only while idle and powered up.
	assign edge_cmd = (rc_prev_reg && !rc_s && !cs_s) ||
		(cs_prev_reg && !cs_s && !rc_s); // RULE_04
	assign start_cmd  = edge_cmd && st_reg == ST_ACQ && !pd_s // RULE_03
		&& !cont_s;
	assign restart    = edge_cmd && st_reg == ST_ACQ && !pd_s // RULE_07
		&& cont_s;
	// Back-to-back conversions need select, read/convert and pd low.
	assign auto_start = cont_s && st_reg == ST_ACQ && !restart && // RULE_01
		!cs_s && !rc_s && !pd_s && tmr_reg == 16'h0000;
	assign conv_end   = st_reg == ST_CONV && tmr_reg == 16'h0000;
	assign pd_fall    = pd_prev_reg && !pd_s;
	assign pd_long    = pd_cnt_reg == 8'(PD_RESET_CYC);

	// Conversion sequencer; the acquisition timer also paces continuous.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg     <= ST_ACQ;
			tmr_reg    <= 16'h0000;
			busy_n_reg <= 1'b1;
		end else begin
			case (st_reg)
			ST_ACQ: begin
				if (start_cmd || auto_start) begin
					st_reg     <= ST_CONV;
					tmr_reg    <= 16'(CONV_CYC - 1);
					busy_n_reg <= 1'b0; // RULE_18
				end else if (restart) begin
					tmr_reg <= 16'(ACQ_CYC - 1);
				end else if (tmr_reg != 16'h0000) begin
					tmr_reg <= tmr_reg - 16'h0001;
				end
			end
			ST_CONV: begin
				if (conv_end) begin
					st_reg     <= ST_ACQ;
					tmr_reg    <= 16'(ACQ_CYC - 1); // RULE_17
					busy_n_reg <= 1'b1; // RULE_18
				end else begin
					tmr_reg <= tmr_reg - 16'h0001;
				end
			end
			default: begin
				st_reg     <= ST_ACQ;
				tmr_reg    <= 16'h0000;
				busy_n_reg <= 1'b1;
			end
			endcase
		end
	end

	// Length of the current power-down pulse, saturating at the minimum.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pd_cnt_reg <= 8'h00;
		end else if (!pd_s) begin
			pd_cnt_reg <= 8'h00;
		end else if (!pd_long) begin
			pd_cnt_reg <= pd_cnt_reg + 8'h01;
		end
	end

	// Channel selection. The pin levels are read only in manual mode, so
	// the device never captures its own drive.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_chan_reg <= 2'h0;
			latch_reg    <= 2'h0;
		end else if ((cont_s || cont_prev_reg) && pd_s) begin
			sel_chan_reg <= 2'h0; // RULE_08
			latch_reg    <= 2'h0;
		end else if (pd_fall && pd_long && st_reg == ST_ACQ) begin
			sel_chan_reg <= 2'h0; // RULE_12
			latch_reg    <= 2'h0;
		end else if (cont_s && !cont_prev_reg) begin
			sel_chan_reg <= latch_reg; // RULE_09
		end else if (cont_s && (conv_end || restart)) begin
			sel_chan_reg <= next_chan(sel_chan_reg); // RULE_06 RULE_13
		end else if (!cont_s && start_cmd) begin
			latch_reg <= addr_s; // RULE_02 RULE_16
		end else if (!cont_s && conv_end) begin
			sel_chan_reg <= latch_reg; // RULE_17
		end
	end

	// Pins become outputs only while continuous mode is seen.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= cont_s; // RULE_10
		end
	end

	// Any power-down during a conversion spoils its result.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bad_acc_reg <= 1'b0;
		end else if (start_cmd || auto_start) begin
			bad_acc_reg <= pd_s;
		end else if (st_reg == ST_CONV && pd_s) begin
			bad_acc_reg <= 1'b1; // RULE_05
		end
	end

	// Result report; the data belong to the channel just converted.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_chan     <= 2'h3;
			result_strobe <= 1'b0;
			result_bad    <= 1'b0;
			analog_on     <= 1'b0;
		end else begin
			result_strobe <= conv_end;
			analog_on     <= !pd_s; // RULE_05
			if (conv_end) begin
				data_chan  <= sel_chan_reg; // RULE_11
				result_bad <= bad_acc_reg || pd_s; // RULE_05
			end
		end
	end

	// The driven address is the channel being acquired or converted.
	assign link.addr_dev_o  = sel_chan_reg; // RULE_11
	assign link.addr_dev_oe = oe_reg;
	assign link.busy_n      = busy_n_reg;
	assign conv_chan        = sel_chan_reg;
endmodule

// ---- rtl/adc_seq_host.sv ----
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module adc_seq_host #(
	parameter int SETTLE_CYC = adc_seq_pkg::SETTLE_CYC_DEF
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	adc_link_if.host         link
);
	import adc_seq_pkg::*;

	if (SETTLE_CYC < 1 || SETTLE_CYC > 16777215) begin : g_chk
		$error("SETTLE_CYC out of range");
	end

	logic [3:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic        w_lane0_reg;
	logic [4:0]  ctrl_reg;
	logic        done_reg;
	logic        pend_reg;
	logic [2:0]  st_s;
	logic        busy_prev_reg;
	logic [3:0]  pulse_reg;
	logic [7:0]  pd_cnt_reg;
	logic [23:0] settle_reg;
	logic        pd_out_next;
	logic        cont_next;
	logic [OE_GAP-1:0] gap_reg;
	logic        wr_go;
	logic        wr_cmd;
	logic        busy_rise;
	logic        can_start;

	// Device outputs arrive from outside and are synchronised.
	sync2 #(
		.W    (3),
		.INIT (3'h4)
	) u_stat_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({link.busy_n, link.chan_addr_bit1, link.chan_addr_bit0}),
		.q      (st_s)
	);

	assign wr_go     = !awready && !wready && !bvalid;
	assign wr_cmd    = wr_go && w_lane0_reg && aw_addr_reg == CMD_OFS;
	assign busy_rise = st_s[2] && !busy_prev_reg;
	assign can_start = pend_reg && pulse_reg == 4'h0 && st_s[2] &&
		!link.power_down; // RULE_04

	// Write channel: address and data taken in either order, then answer.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			awready     <= 1'b1;
			wready      <= 1'b1;
			bvalid      <= 1'b0;
			bresp       <= RESP_OKAY;
			aw_addr_reg <= 4'h0;
			w_data_reg  <= 32'h0000_0000;
			w_lane0_reg <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				awready     <= 1'b0;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				wready      <= 1'b0;
				w_data_reg  <= wdata;
				w_lane0_reg <= wstrb[0];
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp  <= (aw_addr_reg == CTRL_OFS ||
					aw_addr_reg == CMD_OFS) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Read channel; unmapped addresses read zero with an error answer.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= RESP_OKAY;
			case (araddr)
			CTRL_OFS:   rdata <= 32'(ctrl_reg);
			STATUS_OFS: rdata <= 32'({st_s[1:0], 3'h0, pend_reg,
				link.power_down, link.continuous_mode_sel,
				done_reg, !st_s[2]});
			default: begin
				rdata <= 32'h0000_0000;
				rresp <= (araddr == CMD_OFS) ? RESP_OKAY : RESP_SLVERR;
			end
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Control register and the sticky end-of-conversion flag; a busy rise
	// in the cycle of a clear still leaves the flag set.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg      <= CTRL_RESET;
			done_reg      <= 1'b0;
			busy_prev_reg <= 1'b1;
		end else begin
			busy_prev_reg <= st_s[2];
			if (wr_go && w_lane0_reg && aw_addr_reg == CTRL_OFS) begin
				ctrl_reg <= w_data_reg[4:0];
			end
			if (busy_rise) begin
				done_reg <= 1'b1;
			end else if (wr_cmd && w_data_reg[CMD_CLEAR_BIT]) begin
				done_reg <= 1'b0;
			end
		end
	end

	// Start requests wait for busy high, then emit one command edge.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg  <= 1'b0;
			pulse_reg <= 4'h0;
		end else begin
			if (wr_cmd && w_data_reg[CMD_START_BIT]) begin
				pend_reg <= 1'b1;
			end else if (can_start) begin
				pend_reg <= 1'b0;
			end
			if (can_start) begin
				pulse_reg <= 4'(RC_LOW_CYC);
			end else if (pulse_reg != 4'h0) begin
				pulse_reg <= pulse_reg - 4'h1;
			end
		end
	end

	// Power-down stays high for the minimum pulse, and continuous mode
	// waits for the reference capacitors to settle afterwards.
	assign pd_out_next = ctrl_reg[CTRL_PD_BIT] ||
		(link.power_down && pd_cnt_reg < 8'(PD_RESET_CYC)); // RULE_12
	assign cont_next   = ctrl_reg[CTRL_CONT_BIT] && !pd_out_next &&
		settle_reg == 24'h00_0000; // RULE_14 RULE_15

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pd_cnt_reg <= 8'h00;
			settle_reg <= 24'(SETTLE_CYC);
		end else if (link.power_down) begin
			pd_cnt_reg <= (pd_cnt_reg < 8'(PD_RESET_CYC)) ?
				pd_cnt_reg + 8'h01 : pd_cnt_reg;
			settle_reg <= 24'(SETTLE_CYC);
		end else begin
			pd_cnt_reg <= 8'h00;
			if (settle_reg != 24'h00_0000) begin
				settle_reg <= settle_reg - 24'h00_0001;
			end
		end
	end

	// Pin drive. In continuous mode read/convert stays low and a restart
	// is a select pulse; the address pins are released to the device and
	// retaken only after a gap so the two drivers never overlap.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			link.power_down          <= 1'b1;
			link.continuous_mode_sel <= 1'b0;
			link.cs_n                <= 1'b1;
			link.rd_conv             <= 1'b1;
			link.addr_host_o         <= 2'h0;
			link.addr_host_oe        <= 1'b0;
			gap_reg                  <= '1;
		end else begin
			link.power_down          <= pd_out_next;
			link.continuous_mode_sel <= cont_next;
			link.cs_n    <= !ctrl_reg[CTRL_CS_BIT] ||
				(cont_next && pulse_reg != 4'h0);
			link.rd_conv <= !cont_next && pulse_reg == 4'h0;
			link.addr_host_o  <= ctrl_reg[CTRL_ADDR_LSB+1:CTRL_ADDR_LSB];
			gap_reg           <= {gap_reg[OE_GAP-2:0], cont_next};
			link.addr_host_oe <= !cont_next && gap_reg == '0; // RULE_10
		end
	end
endmodule

// ---- dv/adc_channel_sequencer_checker.sv ----
`timescale 1ns/1ps
// Watches the link between the host end and the converter end.
module adc_channel_sequencer_checker #(
	parameter int CONV_CYC = adc_seq_pkg::CONV_CYC_DEF
) (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       cs_n,
	input wire logic       rd_conv,
	input wire logic       power_down,
	input wire logic       continuous_mode_sel,
	input wire logic       busy_n,
	input wire logic [1:0] addr_dev_o,
	input wire logic       addr_dev_oe,
	input wire logic       addr_host_oe
);
	logic [15:0] low_cnt_reg;

	// Counts busy-low cycles, so a stretched or restarted conversion shows.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			low_cnt_reg <= 16'h0000;
		end else if (!busy_n) begin
			low_cnt_reg <= low_cnt_reg + 16'h0001;
		end else begin
			low_cnt_reg <= 16'h0000;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// A manual command edge, then busy falls after the pin synchronisers.
	sequence s_manual_cmd;
		$fell(rd_conv) && !cs_n && busy_n && !power_down
			&& !continuous_mode_sel && !$past(power_down);
	endsequence
	sequence s_conv_begins;
		##[2:4] !busy_n;
	endsequence
	sequence s_conv_end;
		$rose(busy_n);
	endsequence

	a_busy_width: assert property (s_conv_end |-> low_cnt_reg == 16'(CONV_CYC))
		else $error("busy low width differs from conversion time");
	a_busy_bound: assert property (low_cnt_reg <= 16'(CONV_CYC))
		else $error("busy held low past conversion time");
	a_pins_one_driver: assert property (!(addr_dev_oe && addr_host_oe))
		else $error("both ends drive the address pins");
	a_cont_drives_pins: assert property ($rose(continuous_mode_sel) |-> ##[1:6] addr_dev_oe)
		else $error("device did not take the address pins");
	a_manual_frees_pins: assert property ($fell(continuous_mode_sel) |-> ##[1:6] !addr_dev_oe)
		else $error("device kept the address pins in manual mode");
	a_cont_step_up: assert property (s_conv_end ##0 (continuous_mode_sel && addr_dev_oe
		&& $past(addr_dev_oe) && !power_down) |-> addr_dev_o == $past(addr_dev_o) + 2'h1)
		else $error("continuous address did not step by one");
	a_manual_addr_hold: assert property ($changed(addr_dev_o) && !continuous_mode_sel
		&& !$past(continuous_mode_sel, 6) && !power_down && !$past(power_down, 6)
		|-> $rose(busy_n))
		else $error("manual channel changed away from busy rise");
	a_pd_blocks_start: assert property (power_down && $past(power_down, 3) |-> !$fell(busy_n))
		else $error("conversion started while powered down");
	a_start_latency: assert property (s_manual_cmd |-> s_conv_begins)
		else $error("manual command did not start a conversion");
endmodule

// ---- dv/adc_channel_sequencer_tb.sv ----
`timescale 1ns/1ps
module adc_channel_sequencer_tb;
	import adc_seq_pkg::*;
	localparam int          CONV  = 20;
	localparam logic [31:0] START = 32'h1 << CMD_START_BIT;
	logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, conv_chan, data_chan;
	logic        result_strobe, result_bad, analog_on;
	int          n_errors, comparisons;

	adc_link_if adc_link_if_i ();
	adc_seq_host #(.SETTLE_CYC(10)) adc_seq_host_i (.clk(clk), .arst_n(arst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .link(adc_link_if_i));
	adc_seq_device #(.CONV_CYC(CONV)) adc_seq_device_i (.clk(clk),
		.arst_n(arst_n), .link(adc_link_if_i), .conv_chan(conv_chan),
		.data_chan(data_chan), .result_strobe(result_strobe),
		.result_bad(result_bad), .analog_on(analog_on));
	adc_channel_sequencer_checker #(.CONV_CYC(CONV))
		adc_channel_sequencer_checker_i (.clk(clk), .arst_n(arst_n),
		.cs_n(adc_link_if_i.cs_n), .rd_conv(adc_link_if_i.rd_conv),
		.power_down(adc_link_if_i.power_down),
		.continuous_mode_sel(adc_link_if_i.continuous_mode_sel),
		.busy_n(adc_link_if_i.busy_n), .addr_dev_o(adc_link_if_i.addr_dev_o),
		.addr_dev_oe(adc_link_if_i.addr_dev_oe),
		.addr_host_oe(adc_link_if_i.addr_host_oe));

	// Free-running 250 MHz clock.
	always #2 clk = ~clk;

	task automatic complete_run();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	// A wait that runs out is a mismatch and ends the run.
	task automatic stall(input string what);
		n_errors++;
		$display("BAD wait %s expected event seen timeout", what);
		complete_run();
	endtask

	// Control word; chip select stays enabled so both start edges are live.
	function automatic logic [31:0] ctrl(input logic c, input logic p, input logic [1:0] a);
		ctrl = 32'h0;
		ctrl[CTRL_CONT_BIT] = c;
		ctrl[CTRL_PD_BIT] = p;
		ctrl[CTRL_ADDR_LSB +: 2] = a;
		ctrl[CTRL_CS_BIT] = 1'b1;
	endfunction

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok, w_ok;
		int   n;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			n++;
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
			if (n > 100) stall("write address");
		end
		while (bvalid !== 1'b1) begin
			@(posedge clk);
			n++;
			if (n > 200) stall("write response");
		end
		bready <= 1'b0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (n > 100) stall("read address");
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) begin
			@(posedge clk);
			n++;
			if (n > 200) stall("read data");
		end
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	// Waits for busy low (sel set) or a result strobe, sampled after the edge.
	task automatic wait_ev(input logic sel);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (n > 4000) stall("conversion event");
		end while (sel ? adc_link_if_i.busy_n !== 1'b0 : result_strobe !== 1'b1);
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(CTRL_OFS, d, r);
		chk("ctrl reset", 32'(CTRL_RESET), d);
		axi_read(4'hc, d, r);
		chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
		axi_write(4'hc, 32'h1f, RESP_SLVERR);
		axi_read(CMD_OFS, d, r);
		chk("cmd read", 32'h0, d);
		axi_read(CTRL_OFS, d, r);
		chk("ctrl after unmapped", 32'(CTRL_RESET), d);
		$display("done: registers");
	endtask

	task automatic t_manual();
		logic [31:0] d;
		logic [1:0]  r;
		axi_write(CTRL_OFS, ctrl(1'b0, 1'b0, 2'h2), RESP_OKAY);
		axi_write(CMD_OFS, START, RESP_OKAY);
		wait_ev(1'b0);
		chk("first data chan", 32'h0, 32'(data_chan));
		chk("first conv chan", 32'h2, 32'(conv_chan));
		axi_write(CTRL_OFS, ctrl(1'b0, 1'b0, 2'h1), RESP_OKAY);
		axi_write(CMD_OFS, START, RESP_OKAY);
		wait_ev(1'b0);
		chk("second data chan", 32'h2, 32'(data_chan));
		chk("second conv chan", 32'h1, 32'(conv_chan));
		axi_read(STATUS_OFS, d, r);
		chk("status pins", 32'h1, 32'(d[STAT_ADDR_LSB +: 2]));
		$display("done: manual");
	endtask

	// Seed is the last latched address; the sequence wraps after three.
	task automatic t_cont();
		axi_write(CTRL_OFS, ctrl(1'b1, 1'b0, 2'h1), RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			wait_ev(1'b0);
			chk("cont data chan", 32'((i + 1) % 4), 32'(data_chan));
			chk("cont pins", 32'((i + 2) % 4), 32'({adc_link_if_i.chan_addr_bit1,
				adc_link_if_i.chan_addr_bit0}));
		end
		axi_write(CMD_OFS, START, RESP_OKAY);
		wait_ev(1'b0);
		chk("restart data chan", 32'h2, 32'(data_chan));
		$display("done: continuous");
	endtask

	task automatic t_pd_cont();
		axi_write(CTRL_OFS, ctrl(1'b1, 1'b1, 2'h1), RESP_OKAY);
		repeat (60) @(posedge clk);
		#1;
		chk("analog off", 32'h0, 32'(analog_on));
		axi_write(CTRL_OFS, ctrl(1'b1, 1'b0, 2'h1), RESP_OKAY);
		wait_ev(1'b0);
		chk("data chan after pd", 32'h0, 32'(data_chan));
		$display("done: continuous power-down");
	endtask

	// Power-down lands mid-conversion, then a long idle pulse clears the latch.
	task automatic t_pd_bad();
		axi_write(CTRL_OFS, ctrl(1'b0, 1'b0, 2'h1), RESP_OKAY);
		repeat (10) @(posedge clk);
		axi_write(CMD_OFS, START, RESP_OKAY);
		wait_ev(1'b1);
		axi_write(CTRL_OFS, ctrl(1'b0, 1'b1, 2'h1), RESP_OKAY);
		wait_ev(1'b0);
		chk("bad flag set", 32'h1, 32'(result_bad));
		repeat (100) @(posedge clk);
		axi_write(CTRL_OFS, ctrl(1'b0, 1'b0, 2'h3), RESP_OKAY);
		axi_write(CMD_OFS, START, RESP_OKAY);
		wait_ev(1'b0);
		chk("bad flag clear", 32'h0, 32'(result_bad));
		chk("data chan reset", 32'h0, 32'(data_chan));
		chk("conv chan next", 32'h3, 32'(conv_chan));
		$display("done: power-down flag");
	endtask

	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr} = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		n_errors = 0;
		comparisons = 0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_manual();
		t_cont();
		t_pd_cont();
		t_pd_bad();
		complete_run();
	end
endmodule
